// >>> rtl/mem_pkg.sv
/*
 * Constants and carriers for the retention RAM arbiter controller.
 * Assumes one 250 MHz clock, byte addresses on every requester and
 * synchronous RAM cells that answer one cycle after their command.
 */
package mem_pkg;
    // ==========================================================
    // Address map of the three retention_ram banks
    // ==========================================================
    localparam logic [31:0] RAM_BASE = 32'h07fc0000;
    localparam logic [2:0][31:0] BANK_START = {32'h07fc7000, 32'h07fc4000, 32'h07fc0000};
    localparam logic [2:0][31:0] BANK_END = {32'h07fcbfff, 32'h07fc6fff, 32'h07fc3fff};
    // Bit set: the bank sits under the second arbiter.
    localparam logic [2:0] BANK_ARB = 3'h6;
    localparam int IDX_W = 13;

    // ==========================================================
    // Requesters and timing
    // ==========================================================
    localparam int M_SYS = 0;
    localparam int M_OTP = 1;
    localparam int M_RADIO = 2;
    localparam logic [8:0] CLK_MHZ = 9'h0fa;
    localparam logic [8:0] RADIO_MHZ = 9'h010;
    localparam logic [2:0] SYS_WAIT_MAX = 3'h4;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic rvalid;
        logic err;
        logic [31:0] rdata;
    } mem_rsp_t;

    typedef struct packed {
        logic en;
        logic write;
        logic [IDX_W-1:0] index;
        logic [31:0] wdata;
    } cell_cmd_t;
endpackage

// >>> rtl/ram_arbiter_controller.sv
/*
 * Retention RAM controller: three requesters, two time-sharing arbiters,
 * three bank command ports. Assumes requesters hold a request until ready
 * and that bank_on comes from logic on ref_clk.
 */
`timescale 1ns/100ps
// What this block does
// - Two time-sharing arbiters let two of the masters reach banks on different arbiters together.
// - A mux-demux steers each request to the owning arbiter and returns data.
// - Requesters are the system bus, the memory copy path and the radio core.
// - Colliding requesters share an arbiter by time division, none stalled long.
// - Copy path and radio core outrank the system bus masters.
// - The radio exchange-memory port always runs at 16 MHz.
// - A separate port lets the copy path write RAM after power-up and wake-up.
// - RAM is three retention banks of 12 kB, 16 kB and 20 kB.
// - Banks form one contiguous space so unused banks may stay unpowered.
// - Bus transfers become cell signalling; masters see no banks or arbitration.
// - 16 kB bank at 0x07FC0000, then 12 kB, then 20 kB ending 0x07FCBFFF.
module ram_arbiter_controller (
    input wire logic ref_clk, // 250 MHz clock
    input wire logic rst_n, // synchronous reset, active low
    input wire mem_pkg::mem_req_t sys_req, // system bus master request
    output logic sys_ready, // system request taken
    output mem_pkg::mem_rsp_t sys_rsp, // system answer
    input wire mem_pkg::mem_req_t otp_req, // copy path request
    output logic otp_ready, // copy path request taken
    output mem_pkg::mem_rsp_t otp_rsp, // copy path answer
    input wire mem_pkg::mem_req_t radio_req, // radio exchange-memory request
    output logic radio_ready, // radio request taken
    output mem_pkg::mem_rsp_t radio_rsp, // radio answer
    output logic radio_tick, // 16 MHz enable pulse of the radio port
    input wire logic [2:0] bank_on, // bank powered, one bit per bank
    output mem_pkg::cell_cmd_t [2:0] cell_cmd, // command to each bank
    input wire logic [2:0][31:0] cell_rdata // bank read data, one cycle after en
);
    mem_pkg::mem_req_t [2:0] req;
    mem_pkg::mem_rsp_t [2:0] rsp_reg;
    mem_pkg::cell_cmd_t [2:0] cmd_reg;
    mem_pkg::cell_cmd_t [2:0] cmd_next;
    logic [2:0][2:0] hit;
    logic [2:0][1:0] bk;
    logic [2:0][31:0] ofs;
    logic [2:0] live, ok, bad, ready;
    logic [2:0][1:0] want;
    logic [1:0][2:0] g;
    logic [1:0][2:0] wait_reg;
    logic [1:0] rr_reg;
    logic [8:0] acc_reg;
    logic [8:0] acc_sum;
    logic tick_reg;
    logic [2:0] s1_v, s1_err, s2_v, s2_err;
    logic [2:0][1:0] s1_bk, s2_bk;

    assign req = {radio_req, otp_req, sys_req};
    assign {radio_ready, otp_ready, sys_ready} = ready;
    assign {radio_rsp, otp_rsp, sys_rsp} = rsp_reg;
    assign cell_cmd = cmd_reg;
    assign radio_tick = tick_reg;

    // ==========================================================
    // Radio port pacing
    // ==========================================================
    // A phase accumulator gives an average of 16 pulses per 250 cycles.
    assign acc_sum = acc_reg + mem_pkg::RADIO_MHZ;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            acc_reg <= 9'h000;
            tick_reg <= 1'b0;
        end else if (acc_sum >= mem_pkg::CLK_MHZ) begin
            acc_reg <= acc_sum - mem_pkg::CLK_MHZ;
            tick_reg <= 1'b1;
        end else begin
            acc_reg <= acc_sum;
            tick_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Address decode and steering
    // ==========================================================
    for (genvar m = 0; m < 3; m++) begin : g_dec
        for (genvar b = 0; b < 3; b++) begin : g_hit
            assign hit[m][b] = (req[m].addr >= mem_pkg::BANK_START[b]) &&
                               (req[m].addr <= mem_pkg::BANK_END[b]);
        end
        assign bk[m] = hit[m][1] ? 2'h1 : (hit[m][2] ? 2'h2 : 2'h0);
        assign ofs[m] = req[m].addr - mem_pkg::BANK_START[bk[m]];
        // The radio port only presents its request on its own 16 MHz beat.
        assign live[m] = req[m].valid && ((m != mem_pkg::M_RADIO) || tick_reg);
        assign ok[m] = |(hit[m] & bank_on);
        // Unmapped or unpowered targets are taken at once and answered with an error.
        assign bad[m] = live[m] && !ok[m];
        assign want[m][0] = live[m] && ok[m] && !mem_pkg::BANK_ARB[bk[m]];
        assign want[m][1] = live[m] && ok[m] && mem_pkg::BANK_ARB[bk[m]];
        assign ready[m] = bad[m] || g[0][m] || g[1][m];
    end

    // ==========================================================
    // Arbiters
    // ==========================================================
    for (genvar a = 0; a < 2; a++) begin : g_arb
        always_comb begin
            g[a] = 3'h0;
            if (want[mem_pkg::M_SYS][a] && wait_reg[a] == mem_pkg::SYS_WAIT_MAX) begin
                g[a][mem_pkg::M_SYS] = 1'b1;
            end else if (want[mem_pkg::M_OTP][a] && want[mem_pkg::M_RADIO][a]) begin
                g[a][rr_reg[a] ? mem_pkg::M_RADIO : mem_pkg::M_OTP] = 1'b1;
            end else if (want[mem_pkg::M_OTP][a]) begin
                g[a][mem_pkg::M_OTP] = 1'b1;
            end else if (want[mem_pkg::M_RADIO][a]) begin
                g[a][mem_pkg::M_RADIO] = 1'b1;
            end else if (want[mem_pkg::M_SYS][a]) begin
                g[a][mem_pkg::M_SYS] = 1'b1;
            end
        end

        // The wait count bounds how long the high pair can hold off the bus.
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                wait_reg[a] <= 3'h0;
            end else if (want[mem_pkg::M_SYS][a] && !g[a][mem_pkg::M_SYS]) begin
                wait_reg[a] <= wait_reg[a] + 3'h1;
            end else begin
                wait_reg[a] <= 3'h0;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                rr_reg[a] <= 1'b0;
            end else if (g[a][mem_pkg::M_OTP]) begin
                rr_reg[a] <= 1'b1;
            end else if (g[a][mem_pkg::M_RADIO]) begin
                rr_reg[a] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Bank command ports
    // ==========================================================
    for (genvar b = 0; b < 3; b++) begin : g_bank
        always_comb begin
            cmd_next[b] = '0;
            for (int m = 0; m < 3; m++) begin
                if (g[mem_pkg::BANK_ARB[b]][m] && bk[m] == 2'(b)) begin
                    cmd_next[b].en = 1'b1;
                    cmd_next[b].write = req[m].write;
                    cmd_next[b].index = ofs[m][mem_pkg::IDX_W+1:2];
                    cmd_next[b].wdata = req[m].wdata;
                end
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                cmd_reg[b] <= '0;
            end else begin
                cmd_reg[b] <= cmd_next[b];
            end
        end
    end

    // ==========================================================
    // Answer pipeline
    // ==========================================================
    // Every taken request, read or write, is answered three cycles later.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1_v <= 3'h0;
            s2_v <= 3'h0;
            s1_err <= 3'h0;
            s2_err <= 3'h0;
            s1_bk <= '0;
            s2_bk <= '0;
        end else begin
            s1_v <= ready;
            s1_err <= bad;
            s1_bk <= bk;
            s2_v <= s1_v;
            s2_err <= s1_err;
            s2_bk <= s1_bk;
        end
    end

    for (genvar m = 0; m < 3; m++) begin : g_rsp
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                rsp_reg[m] <= '0;
            end else begin
                rsp_reg[m].rvalid <= s2_v[m];
                rsp_reg[m].err <= s2_v[m] && s2_err[m];
                rsp_reg[m].rdata <= (s2_v[m] && !s2_err[m]) ? cell_rdata[s2_bk[m]] : 32'h0;
            end
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_arb_single_grant: assert property ($onehot0(g[0]) && $onehot0(g[1]))
        else $error("Arbiter granted two requesters at once.");
    a_grant_has_request: assert property (((g[0] | g[1]) & ~live) == 3'h0)
        else $error("Grant without a live request.");
    a_sys_wait_bound: assert property (wait_reg[0] <= mem_pkg::SYS_WAIT_MAX)
        else $error("System bus waited past its bound.");
    a_high_over_sys: assert property (g[0][mem_pkg::M_SYS] &&
        (want[mem_pkg::M_OTP][0] || want[mem_pkg::M_RADIO][0]) |->
        wait_reg[0] == mem_pkg::SYS_WAIT_MAX)
        else $error("System bus beat a critical requester.");
    a_radio_on_tick: assert property (radio_ready |-> radio_tick)
        else $error("Radio request taken off its beat.");
    a_tick_spacing: assert property (radio_tick |=> !radio_tick [*8])
        else $error("Radio beat faster than 16 MHz.");
    a_rr_alternate: assert property (g[1][mem_pkg::M_RADIO] && want[mem_pkg::M_OTP][1]
        |=> !rr_reg[1])
        else $error("Round-robin did not pass back to the copy path.");
    a_copy_answer: assert property (otp_ready && !$past(otp_ready) |-> ##3 otp_rsp.rvalid)
        else $error("Copy path answer not three cycles after grant.");
    a_cmd_after_grant: assert property (g[0][mem_pkg::M_SYS] |=> cell_cmd[0].en)
        else $error("Bank command missing after grant.");
    a_off_bank_error: assert property (bad[mem_pkg::M_SYS] |-> ##3 sys_rsp.err)
        else $error("Unpowered bank access not flagged.");
    a_range_error: assert property (sys_req.valid && sys_req.addr < mem_pkg::RAM_BASE
        |-> sys_ready ##3 (sys_rsp.rvalid && sys_rsp.err))
        else $error("Out-of-map access not answered with error.");

    c_high_collide: cover property (want[mem_pkg::M_OTP][1] && want[mem_pkg::M_RADIO][1]);
    c_sys_forced: cover property (g[0][mem_pkg::M_SYS] && want[mem_pkg::M_OTP][0]);
    c_parallel: cover property (g[0] != 3'h0 && g[1] != 3'h0);
    c_radio_read: cover property (radio_rsp.rvalid && !radio_rsp.err);
endmodule

// >>> tb/ram_cells_model.sv
/*
 * Behavioural model of the three retention RAM banks behind the controller.
 * Assumes commands come registered on ref_clk and read data is wanted one cycle later.
 */
`timescale 1ns/100ps
module ram_cells_model (
    input wire logic ref_clk, // bench clock
    input wire mem_pkg::cell_cmd_t [2:0] cell_cmd, // command to each bank
    output logic [2:0][31:0] cell_rdata // read data of each bank
);
    // ==========================================================
    // Bank storage
    // ==========================================================
    logic [31:0] mem [3][8192];

    initial cell_rdata = '0;

    // Data is only valid the cycle after a command; otherwise the bus flips so
    // that a controller sampling at the wrong cycle cannot pass by luck.
    always @(posedge ref_clk) begin
        for (int b = 0; b < 3; b++) begin
            if (cell_cmd[b].en === 1'b1) begin
                if (cell_cmd[b].write === 1'b1) begin
                    mem[b][cell_cmd[b].index] = cell_cmd[b].wdata;
                end
                cell_rdata[b] <= mem[b][cell_cmd[b].index];
            end else begin
                cell_rdata[b] <= ~cell_rdata[b];
            end
        end
    end
endmodule

// >>> tb/tb.sv
/*
 * Self-checking bench for the retention RAM controller with three requesters.
 * Assumes the bank model beside it; answers are matched against queued notes.
 */
`timescale 1ns/100ps
module tb;
    typedef struct {logic [31:0] data; logic err; logic rd; int due;} note_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] bank_on = 3'h7;
    mem_pkg::mem_req_t rq [3] = '{default: '0};
    mem_pkg::mem_rsp_t rsp [3];
    logic rdy [3];
    logic radio_tick;
    mem_pkg::cell_cmd_t [2:0] cmd;
    logic [2:0][31:0] crd;
    logic [31:0] lo [3] = '{32'h07fc0000, 32'h07fc4000, 32'h07fc7000};
    logic [31:0] hi [3] = '{32'h07fc3ffc, 32'h07fc6ffc, 32'h07fcbffc};
    note_t q [3][$];
    logic [31:0] shadow [int];
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int seed = 53;
    int wt;
    int w2;
    int n;

    ram_arbiter_controller ram_arbiter_controller_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .sys_req(rq[0]), .sys_ready(rdy[0]), .sys_rsp(rsp[0]),
        .otp_req(rq[1]), .otp_ready(rdy[1]), .otp_rsp(rsp[1]),
        .radio_req(rq[2]), .radio_ready(rdy[2]), .radio_rsp(rsp[2]),
        .radio_tick(radio_tick), .bank_on(bank_on), .cell_cmd(cmd), .cell_rdata(crd));
    ram_cells_model ram_cells_model_inst (.ref_clk(ref_clk), .cell_cmd(cmd), .cell_rdata(crd));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Called at a clock edge; returns at the edge where the request was taken.
    task automatic req(input int p, input logic w, input logic [31:0] a,
                       input logic [31:0] d, output int waited);
        note_t nt;
        logic ok;
        ok = 1'b0;
        #1 rq[p] = '{valid: 1'b1, write: w, addr: a, wdata: d};
        waited = 0;
        @(posedge ref_clk);
        while (rdy[p] !== 1'b1 && waited < 400) begin
            waited++;
            @(posedge ref_clk);
        end
        check(waited < 400, 1, "grant never came");
        for (int b = 0; b < 3; b++) begin
            if (a >= lo[b] && a <= hi[b] + 32'h3 && bank_on[b]) begin
                ok = 1'b1;
            end
        end
        nt = '{data: 32'h0, err: !ok, rd: !w || !ok, due: cyc + 3};
        if (ok && w) begin
            shadow[a[31:2]] = d;
        end else if (ok) begin
            nt.data = shadow[a[31:2]];
        end
        q[p].push_back(nt);
    endtask

    task automatic idle(input int p);
        #1 rq[p].valid = 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Answer monitor
    // ==========================================================
    always @(posedge ref_clk) begin
        note_t nt;
        if (rq[2].valid === 1'b1 && rdy[2] === 1'b1) begin
            check(radio_tick, 1'b1, "radio taken off beat");
        end
        for (int p = 0; p < 3; p++) begin
            if (rsp[p].rvalid === 1'b1) begin
                if (q[p].size() == 0) begin
                    check(1, 0, "answer without request");
                end else begin
                    nt = q[p].pop_front();
                    check(cyc, nt.due, "answer latency");
                    check(rsp[p].err, nt.err, "error flag");
                    if (nt.rd) check(rsp[p].rdata, nt.data, "read data");
                end
            end
        end
    end

    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        repeat (3) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        @(posedge ref_clk);
        for (int p = 0; p < 3; p++) begin
            for (int b = 0; b < 3; b++) begin
                req(p, 1'b1, lo[b], $random(seed), wt);
                req(p, 1'b1, hi[b], $random(seed), wt);
                req(p, 1'b0, lo[b], 32'h0, wt);
                req(p, 1'b0, hi[b], 32'h0, wt);
            end
            idle(p);
        end
        $display("test bank boundaries done");
        req(0, 1'b0, 32'h07fbfffc, 32'h0, wt);
        req(0, 1'b0, 32'h07fcc000, 32'h0, wt);
        idle(0);
        bank_on = 3'h5;
        req(0, 1'b1, lo[1], 32'h5a5a5a5a, wt);
        req(0, 1'b0, lo[1], 32'h0, wt);
        idle(0);
        bank_on = 3'h7;
        req(0, 1'b0, lo[1], 32'h0, wt);
        idle(0);
        $display("test unmapped and unpowered done");
        // Each port has one driver at a time; the two arbiters must grant in parallel.
        fork
            begin
                req(1, 1'b1, lo[1] + 32'h10, 32'h11, w2);
                idle(1);
            end
            begin
                req(0, 1'b1, lo[0] + 32'h10, 32'h22, wt);
                idle(0);
            end
        join
        check(wt + w2, 0, "parallel grant");
        fork
            begin
                repeat (6) req(1, 1'b1, lo[0] + 32'h20, $random(seed), w2);
                idle(1);
            end
            begin
                @(posedge ref_clk);
                req(0, 1'b0, lo[0], 32'h0, wt);
                check(wt >= 1 && wt <= 5, 1, "system wait");
                idle(0);
            end
        join
        // The copy path keeps the second arbiter busy so every radio beat collides.
        fork
            begin
                repeat (96) req(1, 1'b1, lo[2] + 32'h40, $random(seed), w2);
                idle(1);
            end
            begin
                repeat (4) begin
                    req(2, 1'b1, lo[1] + 32'h40, $random(seed), wt);
                    check(wt <= 40, 1, "radio wait");
                end
                idle(2);
            end
        join
        $display("test arbitration done");
        n = 0;
        repeat (250) begin
            @(posedge ref_clk);
            if (radio_tick === 1'b1) n++;
        end
        check(n, 16, "radio beats per 250 cycles");
        $display("test radio beat done");
        for (int i = 0; i < 24; i++) begin
            int p;
            int b;
            logic [31:0] a;
            p = {$random(seed)} % 3;
            b = {$random(seed)} % 3;
            a = lo[b] + (({$random(seed)} % (hi[b] - lo[b] + 4)) & 32'hfffffffc);
            req(p, 1'b1, a, $random(seed), wt);
            req(p, 1'b0, a, 32'h0, wt);
            idle(p);
        end
        $display("test random traffic done");
        repeat (10) @(posedge ref_clk);
        check(q[0].size() + q[1].size() + q[2].size(), 0, "unanswered requests");
        tally_and_finish();
    end
endmodule
